// *** hdl/cma_alu.sv ***
// Combinational arithmetic, logic and rotate unit for the datapath.
// Assumes the caller registers the result and the carry out.
`timescale 1ns/1ps

module cma_alu
    import cma_pkg::*;
#(
    parameter int DATA_W = CMA_DATA_W
) (
    input wire cma_op_t i_op,
    input wire logic [DATA_W-1:0] i_acc,
    input wire logic [DATA_W-1:0] i_operand,
    input wire logic i_carry,
    output logic [DATA_W-1:0] o_result,
    output logic o_carry,
    output logic o_write_acc
);

    logic [DATA_W:0] wide;

    always_comb begin
        wide = '0;
        o_result = i_acc;
        o_carry = i_carry;
        o_write_acc = 1'b1;
        case (i_op)
            CMA_OP_ADD: begin
                wide = {1'b0, i_acc} + {1'b0, i_operand};
                o_result = wide[DATA_W-1:0];
                o_carry = wide[DATA_W];
            end
            CMA_OP_ADC: begin
                wide = {1'b0, i_acc} + {1'b0, i_operand} + {{DATA_W{1'b0}}, i_carry};
                o_result = wide[DATA_W-1:0];
                o_carry = wide[DATA_W];
            end
            CMA_OP_SUB: begin
                wide = {1'b0, i_acc} - {1'b0, i_operand};
                o_result = wide[DATA_W-1:0];
                o_carry = wide[DATA_W];
            end
            CMA_OP_SBB: begin
                wide = {1'b0, i_acc} - {1'b0, i_operand} - {{DATA_W{1'b0}}, i_carry};
                o_result = wide[DATA_W-1:0];
                o_carry = wide[DATA_W];
            end
            // Logic ops clear carry so a later conditional sees a known value
            CMA_OP_AND: begin
                o_result = i_acc & i_operand;
                o_carry = 1'b0;
            end
            CMA_OP_XOR: begin
                o_result = i_acc ^ i_operand;
                o_carry = 1'b0;
            end
            CMA_OP_OR: begin
                o_result = i_acc | i_operand;
                o_carry = 1'b0;
            end
            CMA_OP_CMP: begin
                wide = {1'b0, i_acc} - {1'b0, i_operand};
                o_result = wide[DATA_W-1:0];
                o_carry = wide[DATA_W];
                o_write_acc = 1'b0;
            end
            CMA_OP_RLC: begin
                o_result = {i_acc[DATA_W-2:0], i_acc[DATA_W-1]};
                o_carry = i_acc[DATA_W-1];
            end
            CMA_OP_RRC: begin
                o_result = {i_acc[0], i_acc[DATA_W-1:1]};
                o_carry = i_acc[0];
            end
            CMA_OP_RAL: begin
                o_result = {i_acc[DATA_W-2:0], i_carry};
                o_carry = i_acc[DATA_W-1];
            end
            CMA_OP_RAR: begin
                o_result = {i_carry, i_acc[DATA_W-1:1]};
                o_carry = i_acc[0];
            end
            CMA_OP_PASS: begin
                o_result = i_operand;
            end
            default: begin
                o_write_acc = 1'b0;
            end
        endcase
    end

endmodule // cma_alu

// *** hdl/cma_datapath.sv ***
// Execution datapath for register moves, arithmetic/logic and accumulator rotates.
// Assumes opcodes arrive with a valid/ready handshake, and that immediate bytes and
// memory reads/writes are served by same-clock logic answering with a one-cycle valid.
//
// Notes on behaviour
// - Move copies register, memory or immediate source into register or memory.
// - Move to memory operand writes source at address formed from H and L.
// - Immediate move source takes the second instruction byte as the value.
// - Move changes only the destination; the source keeps its value.
// - Moves are one byte; immediate moves fetch one extra data byte.
// - ALU ops combine A with A..L, memory at H:L, or immediate byte.
// - All ALU results except compare are written back into A.
// - Operations: add, add carry, subtract, subtract borrow, and, xor, or, compare.
// - Add-with-carry adds current carry into the sum.
// - Subtract-with-borrow also subtracts the current carry flag.
// - Compare sets condition flags from evaluating operand against A.
// - Plain rotates shift A circularly one bit left or right.
// - Rotates through carry form a nine-bit ring with the carry flag.
// - Immediate-form instructions take data from the second instruction byte.
`timescale 1ns/1ps

module cma_datapath
    import cma_pkg::*;
#(
    parameter int DATA_W = CMA_DATA_W,
    parameter int ADDR_W = CMA_ADDR_W
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic i_OP_VALID,
    input wire logic [7:0] i_OPCODE,
    output logic o_OP_READY,
    output logic o_IMM_REQ,
    input wire logic i_IMM_VALID,
    input wire logic [DATA_W-1:0] i_IMM_DATA,
    output logic o_MEM_RD_REQ,
    output logic o_MEM_WR_REQ,
    output logic [ADDR_W-1:0] o_MEM_ADDR,
    output logic [DATA_W-1:0] o_MEM_WDATA,
    input wire logic i_MEM_VALID,
    input wire logic [DATA_W-1:0] i_MEM_RDATA,
    output logic o_DONE,
    output logic o_BAD_OP,
    output logic [DATA_W-1:0] o_ACC,
    output logic o_CARRY,
    output logic o_ZERO,
    output logic o_SIGN,
    output logic o_PARITY_EVEN
);

    // ******************************
    // Decode helpers
    // ******************************
    function automatic logic is_mem(input logic [2:0] code);
        is_mem = (code == CMA_REG_M);
    endfunction

    function automatic cma_op_t alu_sel(input logic [2:0] code);
        case (code)
            3'h0: alu_sel = CMA_OP_ADD;
            3'h1: alu_sel = CMA_OP_ADC;
            3'h2: alu_sel = CMA_OP_SUB;
            3'h3: alu_sel = CMA_OP_SBB;
            3'h4: alu_sel = CMA_OP_AND;
            3'h5: alu_sel = CMA_OP_XOR;
            3'h6: alu_sel = CMA_OP_OR;
            default: alu_sel = CMA_OP_CMP;
        endcase
    endfunction

    function automatic cma_op_t rot_sel(input logic [1:0] code);
        case (code)
            2'h0: rot_sel = CMA_OP_RLC;
            2'h1: rot_sel = CMA_OP_RRC;
            2'h2: rot_sel = CMA_OP_RAL;
            default: rot_sel = CMA_OP_RAR;
        endcase
    endfunction

    typedef enum logic [2:0] {
        CMA_ST_IDLE,
        CMA_ST_IMM,
        CMA_ST_MRD,
        CMA_ST_EXEC,
        CMA_ST_MWR
    } cma_state_t;

    // ******************************
    // State
    // ******************************
    cma_state_t state_r, state_nxt;
    cma_op_t op_r, op_nxt;
    logic [2:0] dst_r, dst_nxt;
    logic [2:0] src_r, src_nxt;
    logic dst_mem_r, dst_mem_nxt;
    logic [DATA_W-1:0] operand_r, operand_nxt;
    logic [DATA_W-1:0] regs_r [CMA_NUM_REGS];
    logic [DATA_W-1:0] regs_nxt [CMA_NUM_REGS];
    logic carry_r, carry_nxt;
    logic zero_r, zero_nxt;
    logic sign_r, sign_nxt;
    logic par_r, par_nxt;
    logic done_r, done_nxt;
    logic bad_r, bad_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;

    logic [DATA_W-1:0] alu_result;
    logic alu_carry;
    logic alu_write_acc;

    logic [1:0] op_class;
    logic [2:0] op_dst;
    logic [2:0] op_src;

    assign op_class = i_OPCODE[CMA_CLASS_HI:CMA_CLASS_LO];
    assign op_dst = i_OPCODE[CMA_DST_HI:CMA_DST_LO];
    assign op_src = i_OPCODE[CMA_SRC_HI:CMA_SRC_LO];

    cma_alu #(
        .DATA_W(DATA_W)
    ) u_alu (
        .i_op(op_r),
        .i_acc(regs_r[CMA_REG_A]),
        .i_operand(operand_r),
        .i_carry(carry_r),
        .o_result(alu_result),
        .o_carry(alu_carry),
        .o_write_acc(alu_write_acc)
    );

    // ******************************
    // Sequencing and execution
    // ******************************
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        dst_nxt = dst_r;
        src_nxt = src_r;
        dst_mem_nxt = dst_mem_r;
        operand_nxt = operand_r;
        regs_nxt = regs_r;
        carry_nxt = carry_r;
        zero_nxt = zero_r;
        sign_nxt = sign_r;
        par_nxt = par_r;
        done_nxt = 1'b0;
        bad_nxt = 1'b0;
        wdata_nxt = wdata_r;
        case (state_r)
            CMA_ST_IDLE: begin
                if (i_OP_VALID) begin
                    dst_nxt = op_dst;
                    src_nxt = op_src;
                    dst_mem_nxt = 1'b0;
                    state_nxt = CMA_ST_EXEC;
                    if (op_class == CMA_CLASS_MOVE) begin
                        op_nxt = CMA_OP_PASS;
                        dst_mem_nxt = is_mem(op_dst);
                        if (is_mem(op_src)) begin
                            state_nxt = CMA_ST_MRD;
                        end else begin
                            operand_nxt = regs_r[op_src];
                        end
                    end else if (op_class == CMA_CLASS_ALU) begin
                        op_nxt = alu_sel(op_dst);
                        dst_nxt = CMA_REG_A;
                        if (is_mem(op_src)) begin
                            state_nxt = CMA_ST_MRD;
                        end else begin
                            operand_nxt = regs_r[op_src];
                        end
                    end else if (op_class == CMA_CLASS_MISC && op_src == CMA_MISC_MOVE_IMM) begin
                        op_nxt = CMA_OP_PASS;
                        dst_mem_nxt = is_mem(op_dst);
                        state_nxt = CMA_ST_IMM;
                    end else if (op_class == CMA_CLASS_MISC && op_src == CMA_MISC_ALU_IMM) begin
                        op_nxt = alu_sel(op_dst);
                        dst_nxt = CMA_REG_A;
                        state_nxt = CMA_ST_IMM;
                    end else if (op_class == CMA_CLASS_MISC && op_src == CMA_MISC_ROT
                                 && !i_OPCODE[CMA_ROT_ZERO_BIT]) begin
                        op_nxt = rot_sel(i_OPCODE[CMA_ROT_HI:CMA_ROT_LO]);
                        dst_nxt = CMA_REG_A;
                    end else begin
                        // Unsupported opcodes are consumed and flagged, state untouched
                        bad_nxt = 1'b1;
                        state_nxt = CMA_ST_IDLE;
                    end
                end
            end
            CMA_ST_IMM: begin
                if (i_IMM_VALID) begin
                    operand_nxt = i_IMM_DATA;
                    state_nxt = CMA_ST_EXEC;
                end
            end
            CMA_ST_MRD: begin
                if (i_MEM_VALID) begin
                    operand_nxt = i_MEM_RDATA;
                    state_nxt = CMA_ST_EXEC;
                end
            end
            CMA_ST_EXEC: begin
                if (op_r == CMA_OP_PASS) begin
                    if (dst_mem_r) begin
                        wdata_nxt = operand_r;
                        state_nxt = CMA_ST_MWR;
                    end else begin
                        regs_nxt[dst_r] = operand_r;
                        done_nxt = 1'b1;
                        state_nxt = CMA_ST_IDLE;
                    end
                end else begin
                    if (alu_write_acc) begin
                        regs_nxt[CMA_REG_A] = alu_result;
                    end
                    carry_nxt = alu_carry;
                    // Rotates keep zero/sign/parity; only carry moves
                    if (op_r inside {CMA_OP_ADD, CMA_OP_ADC, CMA_OP_SUB, CMA_OP_SBB,
                                     CMA_OP_AND, CMA_OP_XOR, CMA_OP_OR, CMA_OP_CMP}) begin
                        zero_nxt = (alu_result == '0);
                        sign_nxt = alu_result[DATA_W-1];
                        par_nxt = ~(^alu_result);
                    end
                    done_nxt = 1'b1;
                    state_nxt = CMA_ST_IDLE;
                end
            end
            CMA_ST_MWR: begin
                if (i_MEM_VALID) begin
                    done_nxt = 1'b1;
                    state_nxt = CMA_ST_IDLE;
                end
            end
            default: begin
                state_nxt = CMA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_r <= CMA_ST_IDLE;
            op_r <= CMA_OP_PASS;
            dst_r <= CMA_REG_A;
            src_r <= CMA_REG_A;
            dst_mem_r <= 1'b0;
            operand_r <= CMA_RESET_BYTE;
            for (int i = 0; i < CMA_NUM_REGS; i++) begin
                regs_r[i] <= CMA_RESET_BYTE;
            end
            carry_r <= 1'b0;
            zero_r <= 1'b0;
            sign_r <= 1'b0;
            par_r <= 1'b0;
            done_r <= 1'b0;
            bad_r <= 1'b0;
            wdata_r <= CMA_RESET_BYTE;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            dst_r <= dst_nxt;
            src_r <= src_nxt;
            dst_mem_r <= dst_mem_nxt;
            operand_r <= operand_nxt;
            regs_r <= regs_nxt;
            carry_r <= carry_nxt;
            zero_r <= zero_nxt;
            sign_r <= sign_nxt;
            par_r <= par_nxt;
            done_r <= done_nxt;
            bad_r <= bad_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // ******************************
    // Outputs
    // ******************************
    // Address uses the low bits of H above all of L; upper H bits are ignored
    assign o_MEM_ADDR = {regs_r[CMA_REG_H][ADDR_W-DATA_W-1:0], regs_r[CMA_REG_L]};
    assign o_MEM_WDATA = wdata_r;
    assign o_OP_READY = (state_r == CMA_ST_IDLE);
    assign o_IMM_REQ = (state_r == CMA_ST_IMM);
    assign o_MEM_RD_REQ = (state_r == CMA_ST_MRD);
    assign o_MEM_WR_REQ = (state_r == CMA_ST_MWR);
    assign o_DONE = done_r;
    assign o_BAD_OP = bad_r;
    assign o_ACC = regs_r[CMA_REG_A];
    assign o_CARRY = carry_r;
    assign o_ZERO = zero_r;
    assign o_SIGN = sign_r;
    assign o_PARITY_EVEN = par_r;

endmodule // cma_datapath

// *** hdl/cma_pkg.sv ***
// Constants shared by the move / arithmetic / rotate datapath.
// Assumes an 8-bit byte-wide memory and an opcode byte with the fields below.
package cma_pkg;

    // ******************************
    // Widths
    // ******************************
    localparam int CMA_DATA_W = 8;
    localparam int CMA_ADDR_W = 14;
    localparam int CMA_NUM_REGS = 7;

    // ******************************
    // Opcode field positions
    // ******************************
    localparam int CMA_CLASS_HI = 7;
    localparam int CMA_CLASS_LO = 6;
    localparam int CMA_DST_HI = 5;
    localparam int CMA_DST_LO = 3;
    localparam int CMA_SRC_HI = 2;
    localparam int CMA_SRC_LO = 0;
    localparam int CMA_ROT_HI = 4;
    localparam int CMA_ROT_LO = 3;
    localparam int CMA_ROT_ZERO_BIT = 5;

    // Instruction classes in bits 7:6
    localparam logic [1:0] CMA_CLASS_MISC = 2'h0;
    localparam logic [1:0] CMA_CLASS_ALU = 2'h2;
    localparam logic [1:0] CMA_CLASS_MOVE = 2'h3;

    // Low three bits of a misc-class opcode
    localparam logic [2:0] CMA_MISC_ROT = 3'h2;
    localparam logic [2:0] CMA_MISC_ALU_IMM = 3'h4;
    localparam logic [2:0] CMA_MISC_MOVE_IMM = 3'h6;

    // Register / operand codes
    localparam logic [2:0] CMA_REG_A = 3'h0;
    localparam logic [2:0] CMA_REG_B = 3'h1;
    localparam logic [2:0] CMA_REG_C = 3'h2;
    localparam logic [2:0] CMA_REG_D = 3'h3;
    localparam logic [2:0] CMA_REG_E = 3'h4;
    localparam logic [2:0] CMA_REG_H = 3'h5;
    localparam logic [2:0] CMA_REG_L = 3'h6;
    localparam logic [2:0] CMA_REG_M = 3'h7;

    // ******************************
    // Datapath operations
    // ******************************
    typedef enum logic [3:0] {
        CMA_OP_ADD,
        CMA_OP_ADC,
        CMA_OP_SUB,
        CMA_OP_SBB,
        CMA_OP_AND,
        CMA_OP_XOR,
        CMA_OP_OR,
        CMA_OP_CMP,
        CMA_OP_RLC,
        CMA_OP_RRC,
        CMA_OP_RAL,
        CMA_OP_RAR,
        CMA_OP_PASS
    } cma_op_t;

    localparam logic [7:0] CMA_RESET_BYTE = 8'h00;

endpackage

// *** sim/cma_datapath_sva.sv ***
// Checker for the datapath handshakes, result timing and held requests.
// Assumes one clock and a synchronous active-high reset, ports as on cma_datapath.
`timescale 1ns/1ps

module cma_datapath_sva
    import cma_pkg::*;
#(
    parameter int DATA_W = CMA_DATA_W,
    parameter int ADDR_W = CMA_ADDR_W
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic i_OP_VALID,
    input wire logic [7:0] i_OPCODE,
    input wire logic o_OP_READY,
    input wire logic o_IMM_REQ,
    input wire logic i_IMM_VALID,
    input wire logic [DATA_W-1:0] i_IMM_DATA,
    input wire logic o_MEM_RD_REQ,
    input wire logic o_MEM_WR_REQ,
    input wire logic [ADDR_W-1:0] o_MEM_ADDR,
    input wire logic [DATA_W-1:0] o_MEM_WDATA,
    input wire logic i_MEM_VALID,
    input wire logic [DATA_W-1:0] i_MEM_RDATA,
    input wire logic o_DONE,
    input wire logic o_BAD_OP,
    input wire logic [DATA_W-1:0] o_ACC,
    input wire logic o_CARRY,
    input wire logic o_ZERO,
    input wire logic o_SIGN,
    input wire logic o_PARITY_EVEN
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    // ********
    // Handshake and result timing
    // ********
    property p_idle_quiet; o_OP_READY |-> !(o_IMM_REQ || o_MEM_RD_REQ || o_MEM_WR_REQ); endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("request while idle");
    property p_take_busy; o_OP_READY && i_OP_VALID |=> o_BAD_OP || !o_OP_READY; endproperty
    a_take_busy: assert property (p_take_busy) else $error("ready after take");
    property p_take_answer; o_OP_READY && i_OP_VALID |-> ##[1:30] (o_DONE || o_BAD_OP); endproperty
    a_take_answer: assert property (p_take_answer) else $error("no completion");
    property p_done_pulse; o_DONE |=> !o_DONE; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done held");
    property p_acc_on_done; $changed(o_ACC) |-> o_DONE; endproperty
    a_acc_on_done: assert property (p_acc_on_done) else $error("acc moved without done");
    property p_flag_on_done; $changed({o_CARRY, o_ZERO, o_SIGN, o_PARITY_EVEN}) |-> o_DONE; endproperty
    a_flag_on_done: assert property (p_flag_on_done) else $error("flags moved without done");
    property p_bad_quiet; o_BAD_OP |-> !o_DONE && $stable(o_ACC) && $stable(o_CARRY); endproperty
    a_bad_quiet: assert property (p_bad_quiet) else $error("bad opcode changed state");
    property p_imm_hold; o_IMM_REQ && !i_IMM_VALID |=> o_IMM_REQ; endproperty
    a_imm_hold: assert property (p_imm_hold) else $error("immediate request dropped");
    property p_imm_done; o_IMM_REQ && i_IMM_VALID |-> ##[2:12] o_DONE; endproperty
    a_imm_done: assert property (p_imm_done) else $error("immediate op not done");
    property p_wr_hold;
        o_MEM_WR_REQ && !i_MEM_VALID |=> o_MEM_WR_REQ && $stable(o_MEM_ADDR) && $stable(o_MEM_WDATA);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write changed before ack");
    property p_wr_done; o_MEM_WR_REQ && i_MEM_VALID |=> o_DONE; endproperty
    a_wr_done: assert property (p_wr_done) else $error("no done after write");
    property p_rd_hold; o_MEM_RD_REQ && !i_MEM_VALID |=> o_MEM_RD_REQ && $stable(o_MEM_ADDR); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read changed before ack");
endmodule // cma_datapath_sva

bind cma_datapath cma_datapath_sva #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_cma_datapath_sva (
    .I_CLK(I_CLK), .I_SRST(I_SRST), .i_OP_VALID(i_OP_VALID), .i_OPCODE(i_OPCODE), .o_OP_READY(o_OP_READY),
    .o_IMM_REQ(o_IMM_REQ), .i_IMM_VALID(i_IMM_VALID), .i_IMM_DATA(i_IMM_DATA), .o_MEM_RD_REQ(o_MEM_RD_REQ),
    .o_MEM_WR_REQ(o_MEM_WR_REQ), .o_MEM_ADDR(o_MEM_ADDR), .o_MEM_WDATA(o_MEM_WDATA), .i_MEM_VALID(i_MEM_VALID),
    .i_MEM_RDATA(i_MEM_RDATA), .o_DONE(o_DONE), .o_BAD_OP(o_BAD_OP), .o_ACC(o_ACC), .o_CARRY(o_CARRY),
    .o_ZERO(o_ZERO), .o_SIGN(o_SIGN), .o_PARITY_EVEN(o_PARITY_EVEN));

// *** sim/cma_datapath_tb_top.sv ***
// Self-checking bench: reference model predicts A and flags, a watcher compares.
// Assumes cma_mem_model serves every memory and second-byte request.
`timescale 1ns/1ps

module cma_datapath_tb_top;
    logic clk, srst, op_valid, slow;
    logic [7:0] opcode, imm_byte, imm_data, rdata, wdata, acc;
    logic [13:0] addr;
    logic ready, imm_req, imm_valid, rd_req, wr_req, mem_valid, done, bad, carry, zero, sign, par;
    logic [7:0] rg [0:6];
    logic [7:0] smem [0:16383];
    logic fc, fz, fs, fp;
    logic [12:0] notes [$];
    logic [15:0] lf;
    int fails, cmp_count;
    logic [15:0] dir [0:13] = '{16'h06ff, 16'h0401, 16'h0c00, 16'h1402, 16'h1c00, 16'h3cfe, 16'h0200,
        16'h0a00, 16'h1200, 16'h1a00, 16'h2200, 16'hf900, 16'hc700, 16'hbf00};

    cma_datapath i_cma_datapath (.I_CLK(clk), .I_SRST(srst), .i_OP_VALID(op_valid), .i_OPCODE(opcode),
        .o_OP_READY(ready), .o_IMM_REQ(imm_req), .i_IMM_VALID(imm_valid), .i_IMM_DATA(imm_data),
        .o_MEM_RD_REQ(rd_req), .o_MEM_WR_REQ(wr_req), .o_MEM_ADDR(addr), .o_MEM_WDATA(wdata),
        .i_MEM_VALID(mem_valid), .i_MEM_RDATA(rdata), .o_DONE(done), .o_BAD_OP(bad), .o_ACC(acc),
        .o_CARRY(carry), .o_ZERO(zero), .o_SIGN(sign), .o_PARITY_EVEN(par));
    cma_mem_model i_cma_mem_model (.i_clk(clk), .i_srst(srst), .i_slow(slow), .i_rd_req(rd_req),
        .i_wr_req(wr_req), .i_addr(addr), .i_wdata(wdata), .i_imm_req(imm_req), .i_imm_byte(imm_byte),
        .o_mem_valid(mem_valid), .o_rdata(rdata), .o_imm_valid(imm_valid), .o_imm_data(imm_data));

    // ********
    // Helpers
    // ********
    function automatic logic [7:0] next_rand();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf[7:0];
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task report_and_stop();
        $display("mismatches=%0d comparisons=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reference: updates shadow registers, memory and flags for one opcode
    task automatic predict(input logic [7:0] op, input logic [7:0] im, output logic bad_e, output logic ui,
                           output int nm);
        logic [2:0] d, s;
        logic [7:0] v, a;
        logic [8:0] t;
        logic [13:0] ad;
        logic mv, al;
        d = op[5:3];
        s = op[2:0];
        ad = {rg[5][5:0], rg[6]};
        a = rg[0];
        mv = op[7:6] == 2'h3 || (op[7:6] == 2'h0 && s == 3'h6);
        al = op[7:6] == 2'h2 || (op[7:6] == 2'h0 && s == 3'h4);
        ui = op[7:6] == 2'h0 && (mv || al);
        v = ui ? im : (s == 3'h7 ? smem[ad] : rg[s]);
        nm = int'(mv && d == 3'h7) + int'((mv || al) && !ui && s == 3'h7);
        bad_e = 1'b0;
        if (mv) begin
            if (d == 3'h7) smem[ad] = v;
            else rg[d] = v;
        end else if (al) begin
            case (d)
                3'h0: t = {1'b0, a} + {1'b0, v};
                3'h1: t = {1'b0, a} + {1'b0, v} + {8'h00, fc};
                3'h2, 3'h7: t = {1'b0, a} - {1'b0, v};
                3'h3: t = {1'b0, a} - {1'b0, v} - {8'h00, fc};
                3'h4: t = {1'b0, a & v};
                3'h5: t = {1'b0, a ^ v};
                default: t = {1'b0, a | v};
            endcase
            {fc, fz, fs, fp} = {t[8], t[7:0] == 8'h00, t[7], ~^t[7:0]};
            if (d != 3'h7) rg[0] = t[7:0];
        end else if (op[7:6] == 2'h0 && s == 3'h2 && !op[5]) begin
            case (op[4:3])
                2'h0: t = {a, a[7]};
                2'h1: t = {a[0], a[0], a[7:1]};
                2'h2: t = {a, fc};
                default: t = {a[0], fc, a[7:1]};
            endcase
            {fc, rg[0]} = t;
        end else begin
            bad_e = 1'b1;
        end
    endtask

    // Notes the expected result, offers the opcode, watches the far-side traffic
    task automatic exec(input logic [7:0] op, input logic [7:0] im);
        logic b, ui;
        int nm, imms, mems, n;
        logic [13:0] ad;
        ad = {rg[5][5:0], rg[6]};
        predict(op, im, b, ui, nm);
        notes.push_back({b, fp, fs, fz, fc, rg[0]});
        opcode <= op;
        imm_byte <= im;
        op_valid <= 1'b1;
        slow <= lf[9];
        do @(posedge clk); while (ready !== 1'b1);
        op_valid <= 1'b0;
        imms = 0;
        mems = 0;
        n = 0;
        while (done !== 1'b1 && bad !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
            if (imm_req && imm_valid) imms++;
            if (mem_valid && (rd_req || wr_req)) begin
                mems++;
                check({2'h0, addr}, {2'h0, ad});
            end
            if (mem_valid && wr_req) check({8'h00, wdata}, {8'h00, smem[ad]});
        end
        check({15'h0, n < 60}, 16'h0001);
        check(16'(imms), {15'h0, ui});
        check(16'(mems), 16'(nm));
    endtask

    // ********
    // Watcher, clock, stimulus, watchdog
    // ********
    always @(posedge clk) begin
        if (!srst && (done === 1'b1 || bad === 1'b1)) begin
            if (notes.size() == 0) check(16'hffff, 16'h0000);
            else check({3'h0, bad, par, sign, zero, carry, acc}, {3'h0, notes.pop_front()});
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        srst = 1'b1;
        op_valid = 1'b0;
        slow = 1'b0;
        opcode = 8'h00;
        imm_byte = 8'h00;
        lf = 16'h0003;
        fails = 0;
        cmp_count = 0;
        {fc, fz, fs, fp} = 4'h0;
        for (int k = 0; k < 7; k++) rg[k] = 8'h00;
        for (int a = 0; a < 16384; a++) smem[a] = a[7:0] ^ 8'ha5;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 7; k++) exec({2'h0, k[2:0], 3'h6}, next_rand());
        foreach (dir[i]) exec(dir[i][15:8], dir[i][7:0]);
        repeat (600) begin
            void'(next_rand());
            exec(lf[7:0], lf[15:8]);
        end
        repeat (3) @(posedge clk);
        report_and_stop();
    end

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule // cma_datapath_tb_top

// *** sim/cma_mem_model.sv ***
// Behavioural memory and second-byte source facing the datapath.
// Assumes requests are held until acknowledged, on the datapath's clock.
`timescale 1ns/1ps

module cma_mem_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_slow,
    input wire logic i_rd_req,
    input wire logic i_wr_req,
    input wire logic [13:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_imm_req,
    input wire logic [7:0] i_imm_byte,
    output logic o_mem_valid,
    output logic [7:0] o_rdata,
    output logic o_imm_valid,
    output logic [7:0] o_imm_data
);
    logic [7:0] mem [0:16383];
    int wait_cnt = 0;

    initial begin
        for (int a = 0; a < 16384; a++) mem[a] = a[7:0] ^ 8'ha5;
        o_mem_valid = 1'b0;
        o_imm_valid = 1'b0;
        o_rdata = 8'h00;
        o_imm_data = 8'h00;
    end

    // Idle data lines toggle so a stale byte never passes for an answer
    always @(posedge i_clk) begin
        o_mem_valid <= 1'b0;
        o_imm_valid <= 1'b0;
        o_rdata <= ~o_rdata;
        o_imm_data <= ~o_imm_data;
        if (i_srst || o_mem_valid || o_imm_valid || !(i_rd_req || i_wr_req || i_imm_req)) begin
            wait_cnt <= 0;
        end else if (wait_cnt < (i_slow ? 3 : 0)) begin
            wait_cnt <= wait_cnt + 1;
        end else if (i_imm_req) begin
            o_imm_valid <= 1'b1;
            o_imm_data <= i_imm_byte;
        end else begin
            o_mem_valid <= 1'b1;
            if (i_wr_req) mem[i_addr] <= i_wdata;
            else o_rdata <= mem[i_addr];
        end
    end
endmodule // cma_mem_model
